/* logic/reset_cause_status.sv */
// Function
// R1: set config-mismatch flag, bit 9, on a configuration mismatch reset.
// R2: bit 8 is software read-write regulator standby control.
// R3: set bit 7 when the external master-clear pin causes a reset.
// R4: set bit 6 whenever a software reset is executed.
// R5: set bit 4 when the watchdog timer expires.
// R6: set bit 3 when waking from sleep mode.
// R7: set bit 2 when waking from idle mode.
// R8: set bit 1 on a brown-out reset.
// R9: set bit 0 on a power-on reset.
// R10: bits 31..10 and bit 5 read zero; writes ignored.
// R11: brown-out and power-on flags stay set until software writes zero.
// R12: a source sets only its own flag; others keep their values.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_status (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register port
	input wire logic [rcs_pkg::ADDR_W-1:0] addr,
	input wire logic [rcs_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [rcs_pkg::DATA_W-1:0] rdata,
	// reset and wake sources, one-cycle pulses on clk_sys
	input wire logic config_mismatch_evt,
	input wire logic software_reset_evt,
	input wire logic watchdog_expiry_evt,
	input wire logic brownout_evt,
	input wire logic wake_from_sleep_evt,
	input wire logic wake_from_idle_evt,
	// master_clear_pin, active low, asynchronous
	input wire logic master_clear_pin_n,
	// regulator and interrupt
	output logic regulator_keep_on,
	output logic irq
);
	import rcs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] cause;
		logic [DATA_W-1:0] mask;
		logic [DATA_W-1:0] evt;
		logic [DATA_W-1:0] rdata;
	} regs_t;

	regs_t q;
	regs_t next_q;
	logic [DATA_W-1:0] hw_set;
	logic ext_pulse;
	logic wr_cause;
	logic wr_mask;
	logic wr_evt;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// the pin is asynchronous, so it is synchronised before use
	pin_event_sync u_pin_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin_n(master_clear_pin_n),
		.pin_level_n(),
		.assert_pulse(ext_pulse)
	);

	// ------------------------------------------------------------
	// hardware set vector
	// ------------------------------------------------------------
	// each source drives only its own bit position
	always_comb begin
		hw_set = '0;
		hw_set[BIT_CFG_MISMATCH] = config_mismatch_evt; // see R1
		hw_set[BIT_EXT_PIN] = ext_pulse; // see R3
		hw_set[BIT_SW_RESET] = software_reset_evt; // see R4
		hw_set[BIT_WDOG] = watchdog_expiry_evt; // see R5
		hw_set[BIT_SLEEP] = wake_from_sleep_evt; // see R6
		hw_set[BIT_IDLE] = wake_from_idle_evt; // see R7
		hw_set[BIT_BROWNOUT] = brownout_evt; // see R8
	end

	// write decode
	assign wr_cause = wr & hit(addr, OFS_CAUSE);
	assign wr_mask = wr & hit(addr, OFS_EVT_MASK);
	assign wr_evt = wr & hit(addr, OFS_EVT_STATUS);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// set wins over a clear in the same cycle, so no event is lost
	always_comb begin
		next_q = q;
		// software writes store any value in the implemented bits, flags cleared by zero
		if (wr_cause) begin
			next_q.cause = wdata & IMPL_MASK; // see R2, R10, R11
		end
		// only the firing source's bit changes; the rest hold
		next_q.cause = next_q.cause | (hw_set & FLAG_MASK); // see R12
		// interrupt mask uses the same layout as the flags
		if (wr_mask) begin
			next_q.mask = wdata & FLAG_MASK;
		end
		// interrupt status clears by writing one
		if (wr_evt) begin
			next_q.evt = q.evt & ~(wdata & FLAG_MASK);
		end
		next_q.evt = next_q.evt | (hw_set & FLAG_MASK);
		// read data stand for exactly one cycle after the strobe
		next_q.rdata = '0;
		if (rd) begin
			if (hit(addr, OFS_CAUSE)) begin
				next_q.rdata = q.cause & IMPL_MASK; // see R10
			end else if (hit(addr, OFS_EVT_MASK)) begin
				next_q.rdata = q.mask;
			end else if (hit(addr, OFS_EVT_STATUS)) begin
				next_q.rdata = q.evt;
			end else begin
				next_q.rdata = '0;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// nrst is the power-on reset: it leaves the power-on flag set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q.cause <= CAUSE_RESET; // see R9
			q.mask <= EVT_MASK_RESET;
			q.evt <= EVT_STATUS_RESET;
			q.rdata <= '0;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rdata = q.rdata;
	// high keeps the regulator on during sleep, low is tracking
	assign regulator_keep_on = q.cause[BIT_REGS]; // see R2
	// level interrupt while any unmasked event flag stands
	assign irq = |(q.evt & q.mask);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_cfg_flag_set: assert property ( // see R1
		@(posedge clk_sys) disable iff (!nrst)
		config_mismatch_evt
			|=> q.cause[BIT_CFG_MISMATCH] && q.evt[BIT_CFG_MISMATCH])
		else $error("config mismatch flag not set");

	a_regulator_write: assert property ( // see R2
		@(posedge clk_sys) disable iff (!nrst)
		wr_cause |=> regulator_keep_on == $past(wdata[BIT_REGS]))
		else $error("regulator control did not follow write");

	a_ext_pin_flag: assert property ( // see R3
		@(posedge clk_sys) disable iff (!nrst)
		$fell(u_pin_sync.q.s2) |=> q.cause[BIT_EXT_PIN]
			##1 (q.cause[BIT_EXT_PIN] || $past(wr_cause)))
		else $error("external pin flag not set");

	a_sw_flag_set: assert property ( // see R4
		@(posedge clk_sys) disable iff (!nrst)
		software_reset_evt && wr_cause && !wdata[BIT_SW_RESET]
			|=> q.cause[BIT_SW_RESET])
		else $error("software reset flag lost to a clear");

	a_wdog_flag_set: assert property ( // see R5
		@(posedge clk_sys) disable iff (!nrst)
		watchdog_expiry_evt |=> q.cause[BIT_WDOG] && q.evt[BIT_WDOG])
		else $error("watchdog flag not set");

	a_sleep_idle_flags: assert property ( // see R6
		@(posedge clk_sys) disable iff (!nrst)
		wake_from_sleep_evt && !wake_from_idle_evt && !wr_cause
			|=> q.cause[BIT_SLEEP]
			&& q.cause[BIT_IDLE] == $past(q.cause[BIT_IDLE]))
		else $error("sleep wake flag wrong");

	a_idle_flag_set: assert property ( // see R7
		@(posedge clk_sys) disable iff (!nrst)
		wake_from_idle_evt |=> q.cause[BIT_IDLE])
		else $error("idle wake flag not set");

	a_brownout_flag_set: assert property ( // see R8
		@(posedge clk_sys) disable iff (!nrst)
		brownout_evt |=> q.cause[BIT_BROWNOUT])
		else $error("brown-out flag not set");

	a_por_flag_held: assert property ( // see R9
		@(posedge clk_sys) disable iff (!nrst)
		q.cause[BIT_POR] && !(wr_cause && !wdata[BIT_POR])
			|=> q.cause[BIT_POR])
		else $error("power-on flag dropped without a write");

	a_unimpl_read_zero: assert property ( // see R10
		@(posedge clk_sys) disable iff (!nrst)
		rd && hit(addr, OFS_CAUSE)
			|=> (rdata & ~IMPL_MASK) == '0
			&& rdata == $past(q.cause))
		else $error("cause read wrong or unimplemented bit set");

	a_flag_clear_zero: assert property ( // see R11
		@(posedge clk_sys) disable iff (!nrst)
		wr_cause && !wdata[BIT_BROWNOUT] && !brownout_evt
			|=> !q.cause[BIT_BROWNOUT])
		else $error("brown-out flag not cleared by zero write");

	a_other_flags_hold: assert property ( // see R12
		@(posedge clk_sys) disable iff (!nrst)
		!wr_cause && hw_set == '0 |=> $stable(q.cause))
		else $error("cause register changed with no source");

	a_read_one_cycle: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		!rd |=> rdata == '0)
		else $error("read data stood outside its cycle");

	// ------------------------------------------------------------
	// checks: flag lifetime and gaps
	// ------------------------------------------------------------
	// gap bits are masked on every path into the register
	a_gap_bits_zero: assert property ( // see R10
		@(posedge clk_sys) disable iff (!nrst)
		(q.cause & ~IMPL_MASK) == '0)
		else $error("unimplemented cause bit holds a one");

	// no source drives bit 8, so only software moves the regulator
	a_regulator_hold: assert property ( // see R2
		@(posedge clk_sys) disable iff (!nrst)
		!wr_cause |=> $stable(regulator_keep_on))
		else $error("regulator control moved without a write");

	// without a write no flag may fall
	a_flags_never_drop: assert property ( // see R12
		@(posedge clk_sys) disable iff (!nrst)
		!wr_cause |=> (q.cause & $past(q.cause)) == $past(q.cause))
		else $error("cause flag dropped without a write");

	// without a write, only flags of firing sources may rise
	a_only_own_flag: assert property ( // see R12
		@(posedge clk_sys) disable iff (!nrst)
		!wr_cause |=> (q.cause & ~$past(q.cause))
			== ($past(hw_set) & ~$past(q.cause)))
		else $error("cause flag rose with no matching source");

	a_brownout_flag_held: assert property ( // see R11
		@(posedge clk_sys) disable iff (!nrst)
		q.cause[BIT_BROWNOUT]
			&& !(wr_cause && !wdata[BIT_BROWNOUT])
			|=> q.cause[BIT_BROWNOUT])
		else $error("brown-out flag dropped without a write");

	// only nrst or a software write of one sets the power-on flag again
	a_por_flag_clear: assert property ( // see R11
		@(posedge clk_sys) disable iff (!nrst)
		wr_cause && !wdata[BIT_POR] |=> !q.cause[BIT_POR])
		else $error("power-on flag not cleared by zero write");

	a_cfg_flag_clear: assert property ( // see R1
		@(posedge clk_sys) disable iff (!nrst)
		wr_cause && !wdata[BIT_CFG_MISMATCH] && !config_mismatch_evt
			|=> !q.cause[BIT_CFG_MISMATCH])
		else $error("config mismatch flag not cleared");

	a_wdog_flag_clear: assert property ( // see R5
		@(posedge clk_sys) disable iff (!nrst)
		wr_cause && !wdata[BIT_WDOG] && !watchdog_expiry_evt
			|=> !q.cause[BIT_WDOG])
		else $error("watchdog flag not cleared");

	// a long pin assertion still counts as one event
	a_ext_pin_pulse: assert property ( // see R3
		@(posedge clk_sys) disable iff (!nrst)
		ext_pulse |=> !ext_pulse)
		else $error("pin event pulse longer than one cycle");

	a_ext_flag_hold: assert property ( // see R3
		@(posedge clk_sys) disable iff (!nrst)
		!ext_pulse && !wr_cause
			|=> q.cause[BIT_EXT_PIN] == $past(q.cause[BIT_EXT_PIN]))
		else $error("pin flag moved with no pin event");

	// ------------------------------------------------------------
	// checks: event status, interrupt and register port
	// ------------------------------------------------------------
	// a one clears a status bit unless its event fires again
	a_evt_clear_one: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		wr_evt && wdata[BIT_WDOG] && !watchdog_expiry_evt
			|=> !q.evt[BIT_WDOG])
		else $error("status bit not cleared by a one");

	a_evt_set_wins: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		software_reset_evt |=> q.evt[BIT_SW_RESET])
		else $error("status bit not set by its event");

	// power-on never raises status, so it can never interrupt
	a_evt_gap_zero: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(q.evt & ~FLAG_MASK) == '0 && (q.mask & ~FLAG_MASK) == '0
			&& !q.evt[BIT_POR])
		else $error("status or mask holds a bit outside its layout");

	a_mask_write: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		wr_mask |=> q.mask == ($past(wdata) & FLAG_MASK))
		else $error("mask did not take the written value");

	a_irq_on_event: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		watchdog_expiry_evt && q.mask[BIT_WDOG] && !wr_mask
			|=> irq)
		else $error("unmasked event raised no interrupt");

	a_irq_needs_mask: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		q.mask == '0 |-> !irq)
		else $error("interrupt with every source masked");

	// status only rises on an event, so irq cannot rise unprompted
	a_irq_no_rise: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		!irq && hw_set == '0 && !wr_mask |=> !irq)
		else $error("interrupt rose with no event");

	a_read_mask: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		rd && hit(addr, OFS_EVT_MASK) |=> rdata == $past(q.mask))
		else $error("mask read wrong");

	a_read_status: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		rd && hit(addr, OFS_EVT_STATUS) |=> rdata == $past(q.evt))
		else $error("status read wrong");

	a_read_unmapped: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		rd && !hit(addr, OFS_CAUSE) && !hit(addr, OFS_EVT_MASK)
			&& !hit(addr, OFS_EVT_STATUS) |=> rdata == '0)
		else $error("unmapped read returned data");

	a_write_unmapped: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		wr && !wr_cause && !wr_mask && !wr_evt && hw_set == '0
			|=> $stable(q.cause) && $stable(q.mask) && $stable(q.evt))
		else $error("unmapped write changed a register");

endmodule : reset_cause_status
`default_nettype wire

/* common/rcs_pkg.sv */
`default_nettype none
package rcs_pkg;

	// ------------------------------------------------------------
	// register port geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 4'h8;

	// ------------------------------------------------------------
	// bit positions of reset_cause_status
	// ------------------------------------------------------------
	localparam int BIT_CFG_MISMATCH = 9;
	localparam int BIT_REGS = 8;
	localparam int BIT_EXT_PIN = 7;
	localparam int BIT_SW_RESET = 6;
	localparam int BIT_WDOG = 4;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_IDLE = 2;
	localparam int BIT_BROWNOUT = 1;
	localparam int BIT_POR = 0;

	// ------------------------------------------------------------
	// masks and reset values
	// ------------------------------------------------------------
	// implemented bits: 9..6 and 4..0
	localparam logic [DATA_W-1:0] IMPL_MASK = 32'h000003df;
	// bits that hardware can set (all implemented but bit 8)
	localparam logic [DATA_W-1:0] FLAG_MASK = 32'h000002df;
	// power-on leaves the brown-out and power-on flags set
	localparam logic [DATA_W-1:0] CAUSE_RESET = 32'h00000003;
	localparam logic [DATA_W-1:0] EVT_MASK_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] EVT_STATUS_RESET = 32'h00000000;

	// address match, shared by write and read decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction : hit

endpackage : rcs_pkg
`default_nettype wire

/* logic/pin_event_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_event_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// asynchronous active-low pin
	input wire logic pin_n,
	// synchronised results
	output logic pin_level_n,
	output logic assert_pulse
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_t;

	sync_t q;
	sync_t next_q;

	// s1 feeds s2 only; s3 keeps last s2 for edge detection
	always_comb begin
		next_q = q;
		next_q.s1 = pin_n;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
	end

	// idle level of an active-low pin is high
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q <= 3'b111;
		end else begin
			q <= next_q;
		end
	end

	// one pulse on the falling edge, i.e. on assertion
	assign pin_level_n = q.s2;
	assign assert_pulse = q.s3 & ~q.s2;

endmodule : pin_event_sync
`default_nettype wire

/* tb/tb_reset_cause_status.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_reset_cause_status;
	import rcs_pkg::*;

	// ------------------------------------------------------------
	// clock, reset and stimulus
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [5:0] evts = 6'h00;
	logic master_clear_pin_n = 1'b1;
	logic [DATA_W-1:0] rdata;
	logic regulator_keep_on;
	logic irq;
	int miscompares = 0;
	int total_checks = 0;
	// flag bit of each event input, in the order of evts
	int evbit [6] = '{BIT_CFG_MISMATCH, BIT_SW_RESET, BIT_WDOG,
		BIT_BROWNOUT, BIT_SLEEP, BIT_IDLE};

	always #50 clk_sys = ~clk_sys;

	reset_cause_status dut_u (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.config_mismatch_evt(evts[0]),
		.software_reset_evt(evts[1]),
		.watchdog_expiry_evt(evts[2]),
		.brownout_evt(evts[3]),
		.wake_from_sleep_evt(evts[4]),
		.wake_from_idle_evt(evts[5]),
		.master_clear_pin_n(master_clear_pin_n),
		.regulator_keep_on(regulator_keep_on),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// outputs are looked at 1 ns after the edge so its updates have landed
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
		input logic [31:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk(what, rdata, exp);
	endtask : rd_chk

	task automatic pulse(input int idx);
		@(posedge clk_sys);
		evts[idx] <= 1'b1;
		@(posedge clk_sys);
		evts[idx] <= 1'b0;
		#1;
	endtask : pulse

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		chk("irq", {31'h0, irq}, 32'h0);
		chk("keep_on", {31'h0, regulator_keep_on}, 32'h0);
		rd_chk("cause", OFS_CAUSE, 32'h00000003);
		rd_chk("mask", OFS_EVT_MASK, 32'h00000000);
		rd_chk("status", OFS_EVT_STATUS, 32'h00000000);
		rd_chk("unmapped", 4'hc, 32'h00000000);
		// flags stay until software writes zero
		wr_reg(OFS_CAUSE, 32'h00000000);
		rd_chk("cause", OFS_CAUSE, 32'h00000000);
	endtask : t_reset_values

	task automatic t_bits_and_regulator;
		wr_reg(OFS_CAUSE, 32'hffffffff);
		rd_chk("cause", OFS_CAUSE, 32'h000003df);
		chk("keep_on", {31'h0, regulator_keep_on}, 32'h1);
		wr_reg(OFS_CAUSE, 32'h00000100);
		rd_chk("cause", OFS_CAUSE, 32'h00000100);
		wr_reg(OFS_CAUSE, 32'h00000000);
		chk("keep_on", {31'h0, regulator_keep_on}, 32'h0);
	endtask : t_bits_and_regulator

	// each source adds its own flag and leaves the others alone
	task automatic t_sources;
		logic [31:0] exp;
		exp = 32'h0;
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			exp[evbit[i]] = 1'b1;
			rd_chk("cause", OFS_CAUSE, exp);
		end
		wr_reg(OFS_CAUSE, 32'h00000000);
		rd_chk("cause", OFS_CAUSE, 32'h00000000);
	endtask : t_sources

	// pin passes a synchroniser, so allow a few cycles
	task automatic t_pin;
		@(posedge clk_sys);
		master_clear_pin_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		master_clear_pin_n <= 1'b1;
		rd_chk("cause", OFS_CAUSE, 32'h00000080);
		wr_reg(OFS_CAUSE, 32'h00000000);
	endtask : t_pin

	task automatic t_interrupt;
		wr_reg(OFS_EVT_STATUS, 32'hffffffff);
		wr_reg(OFS_EVT_MASK, 32'h00000010);
		rd_chk("mask", OFS_EVT_MASK, 32'h00000010);
		pulse(1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		pulse(2);
		chk("irq", {31'h0, irq}, 32'h1);
		rd_chk("status", OFS_EVT_STATUS, 32'h00000050);
		wr_reg(OFS_EVT_STATUS, 32'h00000010);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rd_chk("status", OFS_EVT_STATUS, 32'h00000040);
		wr_reg(OFS_EVT_MASK, 32'h00000000);
	endtask : t_interrupt

	// an event beside a clear of its own flag wins; unmapped writes idle
	task automatic t_set_wins;
		@(posedge clk_sys);
		addr <= OFS_CAUSE;
		wdata <= 32'h00000000;
		wr <= 1'b1;
		evts[1] <= 1'b1;
		@(posedge clk_sys);
		addr <= OFS_EVT_STATUS;
		wdata <= 32'h00000010;
		evts[1] <= 1'b0;
		evts[2] <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		evts[2] <= 1'b0;
		#1;
		rd_chk("cause", OFS_CAUSE, 32'h00000050);
		rd_chk("status", OFS_EVT_STATUS, 32'h00000050);
		wr_reg(4'hc, 32'hffffffff);
		rd_chk("cause", OFS_CAUSE, 32'h00000050);
		rd_chk("mask", OFS_EVT_MASK, 32'h00000000);
		rd_chk("status", OFS_EVT_STATUS, 32'h00000050);
		chk("keep_on", {31'h0, regulator_keep_on}, 32'h0);
	endtask : t_set_wins

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		#1;
		t_reset_values();
		t_bits_and_regulator();
		t_sources();
		t_pin();
		t_interrupt();
		t_set_wins();
		print_verdict();
	end

	// the run needs about 100 cycles; the limit is twenty times that
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end

endmodule : tb_reset_cause_status
`default_nettype wire
